// File: core/wiper_host.sv
// Host controller for a dual up/down wiper potentiometer: drives select,
// step and direction pins of each channel from a simple command port.
// Assumes the device pins are plain inputs driven straight from here.
`timescale 1ns/1ps

// Summary of operation
// - Hold select high through power-up
// - Raise select with step low: no store
// - Power-up recall needs select held high
// - Direction may change while selected
// - Avoid select falling while step low
// - Wait ten ms after store before reselect
module wiper_host #(
    parameter int STORE_GUARD_CYC = wiper_host_pkg::CPH_STORE_CYC
) (
    input wire logic sys_clk,                                      // System clock, 10 MHz
    input wire logic resetn,                                       // Async reset, active low
    input wire logic cmd_valid,                                    // Command offered
    output logic cmd_ready,                                        // Command taken when both high
    input wire logic cmd_chan,                                     // Channel to move
    input wire logic cmd_up,                                       // Direction, 1 moves up
    input wire logic [wiper_host_pkg::POS_W-1:0] cmd_steps,        // Number of steps, 0 to 31
    input wire logic cmd_store,                                    // 1 stores position at end
    output logic busy,                                             // Sequence running
    output logic done,                                             // One-cycle pulse at end
    output logic [wiper_host_pkg::NUM_CHAN-1:0] sel_n,             // Select pins, active low
    output logic [wiper_host_pkg::NUM_CHAN-1:0] step_n,            // Step strobe pins, active low
    output logic [wiper_host_pkg::NUM_CHAN-1:0] dir_up             // Direction pins, 1 is up
);

    localparam int NCH = wiper_host_pkg::NUM_CHAN;
    localparam int GW = $clog2(STORE_GUARD_CYC + 1);

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SELECT,
        ST_LOW,
        ST_HIGH,
        ST_LEAVE
    } seq_state_e;

    seq_state_e state;
    seq_state_e next_state;
    logic chan;
    logic next_chan;
    logic store;
    logic next_store;
    logic up;
    logic next_up;
    logic [wiper_host_pkg::POS_W-1:0] steps_left;
    logic [wiper_host_pkg::POS_W-1:0] next_steps_left;
    logic next_sel_n;
    logic next_step_n;
    logic next_done;
    logic accept;
    logic store_launch;
    logic [NCH-1:0] guard_busy;

    wiper_timer_if tif ();

    wiper_timer u_timer (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tif(tif)
    );

    // ------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------
    // Reselect of a channel waits out its store time
    assign cmd_ready = (state == ST_IDLE) && !guard_busy[cmd_chan];
    assign accept = cmd_valid && cmd_ready;

    // ------------------------------------------------------------
    // Next-state and pin sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_chan = chan;
        next_store = store;
        next_up = up;
        next_steps_left = steps_left;
        next_sel_n = sel_n[chan];
        next_step_n = step_n[chan];
        next_done = 1'h0;
        store_launch = 1'h0;
        tif.start = 1'h0;
        tif.cycles = wiper_host_pkg::SEL_WAIT;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_chan = cmd_chan;
                    next_store = cmd_store;
                    next_up = cmd_up;
                    next_steps_left = cmd_steps;
                    if ((cmd_steps == '0) && !cmd_store) begin
                        // Leaving unstored needs a step; nothing to do
                        next_done = 1'h1;
                    end else begin
                        // Select with step high and direction set up
                        next_sel_n = 1'h0;
                        next_step_n = 1'h1;
                        next_state = ST_SELECT;
                        tif.start = 1'h1;
                        tif.cycles = wiper_host_pkg::SEL_WAIT;
                    end
                end
            end
            ST_SELECT: begin
                if (tif.expired) begin
                    tif.start = 1'h1;
                    if (steps_left == '0) begin
                        // Store only: wait before deselect
                        next_state = ST_HIGH;
                        tif.cycles = wiper_host_pkg::HIGH_WAIT;
                    end else begin
                        next_step_n = 1'h0;
                        next_steps_left = steps_left - 5'h01;
                        next_state = ST_LOW;
                        tif.cycles = wiper_host_pkg::LOW_WAIT;
                    end
                end
            end
            ST_LOW: begin
                if (tif.expired) begin
                    tif.start = 1'h1;
                    if ((steps_left == '0) && !store) begin
                        // Deselect while step stays low
                        next_sel_n = 1'h1;
                        next_state = ST_LEAVE;
                        tif.cycles = wiper_host_pkg::LEAVE_WAIT;
                    end else begin
                        next_step_n = 1'h1;
                        next_state = ST_HIGH;
                        tif.cycles = wiper_host_pkg::HIGH_WAIT;
                    end
                end
            end
            ST_HIGH: begin
                if (tif.expired) begin
                    if (steps_left == '0) begin
                        // Deselect with step high commits the position
                        next_sel_n = 1'h1;
                        store_launch = 1'h1;
                        next_done = 1'h1;
                        next_state = ST_IDLE;
                    end else begin
                        next_step_n = 1'h0;
                        next_steps_left = steps_left - 5'h01;
                        next_state = ST_LOW;
                        tif.start = 1'h1;
                        tif.cycles = wiper_host_pkg::LOW_WAIT;
                    end
                end
            end
            ST_LEAVE: begin
                if (tif.expired) begin
                    // Step back high only once deselected
                    next_step_n = 1'h1;
                    next_done = 1'h1;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            chan <= 1'h0;
            store <= 1'h0;
            up <= 1'h0;
            steps_left <= '0;
            busy <= 1'h0;
            done <= 1'h0;
        end else begin
            state <= next_state;
            chan <= next_chan;
            store <= next_store;
            up <= next_up;
            steps_left <= next_steps_left;
            busy <= (next_state != ST_IDLE);
            done <= next_done;
        end
    end

    // ------------------------------------------------------------
    // Per-channel pins and store guard
    // ------------------------------------------------------------
    // Idle channel keeps its pins steady; each has its own set
    for (genvar i = 0; i < NCH; i++) begin : g_chan
        logic [GW-1:0] guard;
        logic this_chan;

        assign this_chan = (i == int'(next_chan));

        // Select held high from reset so power-up recalls, never stores
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                sel_n[i] <= wiper_host_pkg::RST_SEL_N;
                step_n[i] <= wiper_host_pkg::RST_STEP_N;
            end else if (this_chan) begin
                sel_n[i] <= next_sel_n;
                step_n[i] <= next_step_n;
            end
        end

        // Direction only changes while step is high
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                dir_up[i] <= wiper_host_pkg::RST_DIR;
            end else if (this_chan && accept) begin
                dir_up[i] <= next_up;
            end
        end

        // Store time: no reselect until it runs out
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                guard <= '0;
            end else if (store_launch && (i == int'(chan))) begin
                guard <= GW'(STORE_GUARD_CYC);
            end else if (guard != '0) begin
                guard <= guard - 1'h1;
            end
        end

        assign guard_busy[i] = (guard != '0);
    end

endmodule // wiper_host

// File: core/wiper_host_pkg.sv
// Constants shared by the wiper host controller and its delay timer.
// Assumes a single 10 MHz system clock; all pin timings are least times.
package wiper_host_pkg;

    // ------------------------------------------------------------
    // Clock and channel layout
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int NUM_CHAN = 2;
    localparam int POS_W = 5;
    localparam int TMR_W = 4;

    // ------------------------------------------------------------
    // Pin timing minimums
    // ------------------------------------------------------------
    localparam int T_CI_NS = 100;
    localparam int T_DI_NS = 100;
    localparam int T_IL_NS = 1000;
    localparam int T_IH_NS = 1000;
    localparam int T_IC_NS = 1000;
    localparam int T_CPH_NOSTORE_NS = 250;
    localparam int T_CPH_STORE_MS = 10;

    // ------------------------------------------------------------
    // Timing in clock cycles (least times round up)
    // ------------------------------------------------------------
    localparam int CI_CYC = (T_CI_NS + CLK_NS - 1) / CLK_NS;
    localparam int DI_CYC = (T_DI_NS + CLK_NS - 1) / CLK_NS;
    localparam int IL_CYC = (T_IL_NS + CLK_NS - 1) / CLK_NS;
    localparam int IH_CYC = (T_IH_NS + CLK_NS - 1) / CLK_NS;
    localparam int IC_CYC = (T_IC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CPH_NOSTORE_CYC = (T_CPH_NOSTORE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CPH_STORE_CYC = (T_CPH_STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;

    localparam logic [TMR_W-1:0] SEL_WAIT = TMR_W'((CI_CYC > DI_CYC) ? CI_CYC : DI_CYC);
    localparam logic [TMR_W-1:0] LOW_WAIT = TMR_W'(IL_CYC);
    localparam logic [TMR_W-1:0] HIGH_WAIT = TMR_W'((IH_CYC > IC_CYC) ? IH_CYC : IC_CYC);
    localparam logic [TMR_W-1:0] LEAVE_WAIT = TMR_W'(CPH_NOSTORE_CYC);

    // ------------------------------------------------------------
    // Reset levels of the device pins
    // ------------------------------------------------------------
    localparam logic RST_SEL_N = 1'h1;
    localparam logic RST_STEP_N = 1'h1;
    localparam logic RST_DIR = 1'h0;

endpackage

// File: core/wiper_timer_if.sv
// Start and expiry signals between the wiper host and its delay timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface wiper_timer_if;
    logic start;
    logic [wiper_host_pkg::TMR_W-1:0] cycles;
    logic expired;

    modport ctl (output start, output cycles, input expired);
    modport tmr (input start, input cycles, output expired);
endinterface

// File: core/wiper_timer.sv
// Down-counting delay timer: a start with N cycles expires N cycles later.
// Assumes N is at least one and start is a one-cycle pulse.
`timescale 1ns/1ps

module wiper_timer (
    input wire logic sys_clk,   // System clock
    input wire logic resetn,    // Asynchronous reset, active low
    wiper_timer_if.tmr tif      // Start and expiry
);

    logic [wiper_host_pkg::TMR_W-1:0] count;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count <= '0;
        end else if (tif.start) begin
            count <= tif.cycles - 4'h1;
        end else if (count != '0) begin
            count <= count - 4'h1;
        end
    end

    // Plain count test: gating with start would loop through the sequencer
    assign tif.expired = (count == '0);

endmodule // wiper_timer

// File: testbench/wiper_host_sva.sv
// Checker for the wiper host pin sequences and command port.
// Assumes it is bound to wiper_host and sees only its ports.
`timescale 1ns/1ps

module wiper_host_sva #(
    parameter int STORE_GUARD_CYC = 20
) (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Reset, active low
    input wire logic cmd_valid, // Command offered
    input wire logic cmd_ready, // Command can be accepted
    input wire logic busy, // Sequence running
    input wire logic done, // End pulse
    input wire logic [1:0] sel_n, // Select pins
    input wire logic [1:0] step_n // Step pins
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Cycles since a storing deselect
    // ------------------------------------------------------------
    logic [1:0] sel_q;
    int gap [2];
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sel_q <= 2'h3;
            gap <= '{default: STORE_GUARD_CYC};
        end else begin
            sel_q <= sel_n;
            for (int c = 0; c < 2; c++) begin
                if (sel_n[c] && !sel_q[c] && step_n[c]) begin
                    gap[c] <= 1;
                end else if (gap[c] < STORE_GUARD_CYC) begin
                    gap[c] <= gap[c] + 1;
                end
            end
        end
    end

    a_reset_idle: assert property ($rose(resetn) |-> sel_n == 2'h3 && step_n == 2'h3)
        else $error("pins not idle after reset");
    a_done_pulse: assert property (done |-> !busy ##1 !done)
        else $error("done longer than one cycle");
    a_sel_busy: assert property (sel_n != 2'h3 |-> busy && sel_n != 2'h0)
        else $error("select low outside a single-channel sequence");

    for (genvar c = 0; c < 2; c++) begin : g_ch
        a_sel_fall_high: assert property ($fell(sel_n[c]) |-> step_n[c])
            else $error("select fell with step low");
        a_step_low: assert property ($fell(step_n[c]) |->
            !step_n[c] [*8] ##1 !step_n[c] [*2] ##1 (step_n[c] || sel_n[c]))
            else $error("step low period wrong");
        a_store_done: assert property ($rose(sel_n[c]) && step_n[c] |-> done)
            else $error("store exit without done");
        a_no_store_exit: assert property ($rose(sel_n[c]) && !step_n[c] |->
            ##2 !step_n[c] ##1 (step_n[c] && done))
            else $error("no-store exit sequence wrong");
        a_store_guard: assert property ($fell(sel_n[c]) |-> gap[c] >= STORE_GUARD_CYC)
            else $error("reselect too soon after store");
        c_store: cover property ($rose(sel_n[c]) && step_n[c]);
        c_no_store: cover property ($rose(sel_n[c]) && !step_n[c]);
    end
    c_refused: cover property (cmd_valid && !cmd_ready && !busy);
endmodule // wiper_host_sva

bind wiper_host wiper_host_sva #(.STORE_GUARD_CYC(STORE_GUARD_CYC)) i_wiper_host_sva (
    .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .busy(busy), .done(done), .sel_n(sel_n), .step_n(step_n));

// File: testbench/wiper_dev_model.sv
// Behavioural model of the dual up/down wiper device.
// Assumes clean pin edges from the host; no supply modelling.
`timescale 1ns/1ps

module wiper_dev_model #(
    parameter logic [4:0] INIT = 5'h10,
    parameter int STORE_NS = 1500
) (
    input wire logic [1:0] sel_n, // Select pins
    input wire logic [1:0] step_n, // Step pins
    input wire logic [1:0] dir_up, // Direction pins
    output logic [1:0][4:0] pos, // Wiper counters
    output logic [1:0][4:0] stored, // Stored copies
    output wire logic [1:0][31:0] tap // One-hot taps
);
    for (genvar c = 0; c < 2; c++) begin : g_ch
        time busy_until = 0;
        logic prev = 1'h1;
        initial begin
            stored[c] = INIT;
            pos[c] = INIT;
        end
        always @(negedge step_n[c]) begin
            if (sel_n[c] === 1'h0 && $time >= busy_until) begin
                if (dir_up[c] === 1'h1 && pos[c] != 5'h1F) begin
                    pos[c] <= pos[c] + 5'h01;
                end else if (dir_up[c] === 1'h0 && pos[c] != 5'h00) begin
                    pos[c] <= pos[c] - 5'h01;
                end
            end
        end
        // Store only on a real low-to-high select, else keep position
        always @(sel_n[c]) begin
            if (prev === 1'h0 && sel_n[c] === 1'h1 && step_n[c] === 1'h1) begin
                stored[c] <= pos[c];
                busy_until = $time + STORE_NS;
            end
            prev = sel_n[c];
        end
        assign tap[c] = 32'h1 << pos[c];
    end
endmodule // wiper_dev_model

// File: testbench/updown_wiper_control_tb.sv
// Self-checking bench for the wiper host against the device model.
// Assumes a 10 MHz clock and a shortened store guard.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module updown_wiper_control_tb;
    localparam int GUARD = 20;
    localparam logic [4:0] INIT = 5'h10;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic cmd_valid = 1'h0, cmd_chan = 1'h0, cmd_up = 1'h0, cmd_store = 1'h0;
    logic [4:0] cmd_steps = 5'h00;
    logic cmd_ready, busy, done;
    logic [1:0] sel_n, step_n, dir_up;
    logic [1:0][4:0] pos, stored, exp_pos, exp_st;
    wire logic [1:0][31:0] tap;
    int failures = 0, checks_done = 0, seed = 32'h542E;

    always #50 sys_clk = ~sys_clk;

    wiper_host #(.STORE_GUARD_CYC(GUARD)) i_wiper_host (.sys_clk(sys_clk), .resetn(resetn),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_chan(cmd_chan), .cmd_up(cmd_up),
        .cmd_steps(cmd_steps), .cmd_store(cmd_store), .busy(busy), .done(done),
        .sel_n(sel_n), .step_n(step_n), .dir_up(dir_up));
    wiper_dev_model #(.INIT(INIT), .STORE_NS(1500)) i_wiper_dev_model (.sel_n(sel_n),
        .step_n(step_n), .dir_up(dir_up), .pos(pos), .stored(stored), .tap(tap));

    function automatic logic [4:0] next_pos(input logic [4:0] p, input logic up,
                                            input logic [4:0] n);
        int v;
        v = up ? int'(p) + int'(n) : int'(p) - int'(n);
        return (v > 31) ? 5'h1F : (v < 0) ? 5'h00 : 5'(v);
    endfunction

    task automatic end_of_test();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic run_cmd(input logic ch, input logic up, input logic [4:0] n, input logic st);
        int k;
        k = 0;
        cmd_chan <= ch;
        cmd_up <= up;
        cmd_steps <= n;
        cmd_store <= st;
        cmd_valid <= 1'h1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (cmd_ready !== 1'h1 && k < 200);
        cmd_valid <= 1'h0;
        if (cmd_ready !== 1'h1) begin
            failures++;
            end_of_test();
        end
        exp_pos[ch] = next_pos(exp_pos[ch], up, n);
        if (st) begin
            exp_st[ch] = exp_pos[ch];
        end
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (done !== 1'h1 && k < 800);
        if (done !== 1'h1) begin
            failures++;
            end_of_test();
        end
        `CHK(pos[ch], exp_pos[ch])
        `CHK(stored[ch], exp_st[ch])
        `CHK(tap[ch], 32'h1 << exp_pos[ch])
        `CHK(pos[!ch], exp_pos[!ch])
    endtask

    task automatic check_guard(input logic ch);
        cmd_chan <= ch;
        @(posedge sys_clk);
        `CHK(cmd_ready, 1'h0)
        cmd_chan <= !ch;
        @(posedge sys_clk);
        `CHK(cmd_ready, 1'h1)
    endtask

    initial begin
        exp_pos = {INIT, INIT};
        exp_st = {INIT, INIT};
        repeat (4) @(posedge sys_clk);
        resetn <= 1'h1;
        @(posedge sys_clk);
        `CHK(pos, {INIT, INIT})
        `CHK(sel_n, 2'h3)
        // Saturate at top, store, then hit the guard
        run_cmd(1'h0, 1'h1, 5'h1F, 1'h1);
        check_guard(1'h0);
        run_cmd(1'h0, 1'h0, 5'h03, 1'h1);
        run_cmd(1'h0, 1'h0, 5'h02, 1'h0);
        run_cmd(1'h1, 1'h0, 5'h1F, 1'h0);
        run_cmd(1'h1, 1'h1, 5'h00, 1'h1);
        run_cmd(1'h1, 1'h0, 5'h00, 1'h0);
        repeat (16) begin
            run_cmd(1'($random(seed)), 1'($random(seed)), 5'($random(seed)),
                    1'($random(seed)));
        end
        end_of_test();
    end
endmodule // updown_wiper_control_tb
